// ---- rtl/odpc_pkg.sv ----
// Purpose: Constants and carrier types for the output driver power control bank
// Assumes: 8-bit register words, page number plus register number decode
// Notes:   Shared by the register bank and its bench
package odpc_pkg;
   localparam logic [7:0] ODPC_OFS_PAGE       = 8'h00;
   localparam logic [7:0] ODPC_OFS_RSVD_FIRST = 8'h01;
   localparam logic [7:0] ODPC_OFS_RSVD_LAST  = 8'h1D;
   localparam logic [7:0] ODPC_OFS_ERR_CTRL   = 8'h1E;
   localparam logic [7:0] ODPC_OFS_HP_CTRL    = 8'h1F;
   localparam logic [7:0] ODPC_OFS_SPK_CTRL   = 8'h20;
   localparam logic [7:0] ODPC_OFS_STICKY     = 8'h2C;

   localparam logic [7:0] ODPC_PAGE_ZERO      = 8'h00;
   localparam logic [7:0] ODPC_PAGE_ONE       = 8'h01;

   localparam logic [7:0] ODPC_RST_PAGE       = 8'h00;
   localparam logic [7:0] ODPC_RST_ERR_CTRL   = 8'h00;
   localparam logic [7:0] ODPC_RST_HP_CTRL    = 8'h04;
   localparam logic [7:0] ODPC_RST_SPK_CTRL   = 8'h06;

   // Error control fields
   localparam int ODPC_ERR_SPK_KEEP = 1;
   localparam int ODPC_ERR_HP_KEEP  = 0;
   // Headphone fields
   localparam int ODPC_HP_LEFT_EN   = 7;
   localparam int ODPC_HP_RIGHT_EN  = 6;
   localparam int ODPC_HP_CM_HI     = 4;
   localparam int ODPC_HP_CM_LO     = 3;
   localparam int ODPC_HP_SHORT_PD  = 1;
   localparam int ODPC_HP_SHORT_ST  = 0;
   // Speaker fields
   localparam int ODPC_SPK_EN       = 7;
   localparam int ODPC_SPK_SHORT_ST = 0;
   // Sticky register field
   localparam int ODPC_STICKY_SPK   = 0;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } odpc_req_t;

   typedef struct packed {
      logic       left_headphone_driver_en;
      logic       right_headphone_driver_en;
      logic [1:0] hp_cm_level;
      logic       hp_current_limit;
      logic       spk_driver_en;
   } odpc_drv_t;
endpackage : odpc_pkg

// ---- rtl/odpc_regs.sv ----
// Purpose: Page select and page-one output driver power control registers
// Assumes: Requests come from the control serial front end on ref_clk
// Notes:   Short inputs come from analog detectors and are filtered
//
// Summary of operation
// - Page register holds 8-bit page, reads back, resets to zero.
// - Speaker short clears speaker power bit unless keep select is set.
// - Headphone short in power-down mode clears both power bits unless keep set.
// - Bit seven of headphone register powers left driver; resets zero.
// - Bit six of headphone register powers right driver; resets zero.
// - Two-bit headphone field picks common-mode level; resets to 00.
// - Headphone short limits current if select is 0, powers down if 1.
// - Headphone bit zero reads live short status; resets zero.
// - Bit seven of speaker register powers class-D driver; resets zero.
// - Speaker bit zero reads live class-D short, valid while powered.
// - Class-D short also latches a sticky flag in page-zero register 44.
`timescale 1ns/100ps
module odpc_regs (
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   input  wire odpc_pkg::odpc_req_t req,
   input  wire logic                hp_short_raw,
   input  wire logic                spk_short_raw,
   output logic [7:0]               rdata,
   output logic                     rvalid,
   output logic                     spk_short_sticky,
   output odpc_pkg::odpc_drv_t      drv
);
   import odpc_pkg::*;

   logic [7:0] page_reg;
   logic [7:0] err_ctrl_reg;
   logic [7:0] hp_ctrl_reg;
   logic [7:0] spk_ctrl_reg;
   logic [2:0] hp_sync_reg;
   logic [2:0] spk_sync_reg;
   logic       hp_short_reg;
   logic       spk_short_reg;
   logic       sticky_reg;
   logic       sel_p0;
   logic       sel_p1;
   logic       hp_trip;
   logic       spk_trip;
   logic [7:0] rdata_next;

   assign sel_p0   = (page_reg == ODPC_PAGE_ZERO);
   assign sel_p1   = (page_reg == ODPC_PAGE_ONE);
   assign hp_trip  = hp_short_reg && hp_ctrl_reg[ODPC_HP_SHORT_PD];
   assign spk_trip = spk_short_reg && spk_ctrl_reg[ODPC_SPK_EN];

   // Detector filters: second and third stage must agree
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hp_sync_reg   <= 3'h0;
         spk_sync_reg  <= 3'h0;
         hp_short_reg  <= 1'b0;
         spk_short_reg <= 1'b0;
      end else begin
         hp_sync_reg  <= {hp_sync_reg[1:0], hp_short_raw};
         spk_sync_reg <= {spk_sync_reg[1:0], spk_short_raw};
         if (hp_sync_reg[1] == hp_sync_reg[2]) begin
            hp_short_reg <= hp_sync_reg[2];
         end
         if (spk_sync_reg[1] == spk_sync_reg[2]) begin
            spk_short_reg <= spk_sync_reg[2];
         end
      end
   end

   // Page register, reachable from every page
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         page_reg <= ODPC_RST_PAGE;
      end else if (req.wr && req.addr == ODPC_OFS_PAGE) begin
         page_reg <= req.wdata;
      end
   end

   // Error control register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         err_ctrl_reg <= ODPC_RST_ERR_CTRL;
      end else if (req.wr && sel_p1 && req.addr == ODPC_OFS_ERR_CTRL) begin
         err_ctrl_reg <= req.wdata;
      end
   end

   // Headphone register; hardware clear beats a same-cycle write
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hp_ctrl_reg <= ODPC_RST_HP_CTRL;
      end else begin
         if (req.wr && sel_p1 && req.addr == ODPC_OFS_HP_CTRL) begin
            hp_ctrl_reg <= req.wdata;
         end
         if (hp_trip && !err_ctrl_reg[ODPC_ERR_HP_KEEP]) begin
            hp_ctrl_reg[ODPC_HP_LEFT_EN]  <= 1'b0;
            hp_ctrl_reg[ODPC_HP_RIGHT_EN] <= 1'b0;
         end
      end
   end

   // Speaker register; hardware clear beats a same-cycle write
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         spk_ctrl_reg <= ODPC_RST_SPK_CTRL;
      end else begin
         if (req.wr && sel_p1 && req.addr == ODPC_OFS_SPK_CTRL) begin
            spk_ctrl_reg <= req.wdata;
         end
         if (spk_trip && !err_ctrl_reg[ODPC_ERR_SPK_KEEP]) begin
            spk_ctrl_reg[ODPC_SPK_EN] <= 1'b0;
         end
      end
   end

   // Sticky class-D short flag, cleared by reading it; set wins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sticky_reg <= 1'b0;
      end else if (spk_trip) begin
         sticky_reg <= 1'b1;
      end else if (req.rd && sel_p0 && req.addr == ODPC_OFS_STICKY) begin
         sticky_reg <= 1'b0;
      end
   end

   // Read mux; reserved and unmapped locations read zero
   always_comb begin
      rdata_next = 8'h00;
      if (req.addr == ODPC_OFS_PAGE) begin
         rdata_next = page_reg;
      end else if (sel_p1) begin
         case (req.addr)
            ODPC_OFS_ERR_CTRL: begin
               rdata_next = err_ctrl_reg;
            end
            ODPC_OFS_HP_CTRL: begin
               rdata_next = {hp_ctrl_reg[7:1], hp_short_reg};
            end
            ODPC_OFS_SPK_CTRL: begin
               rdata_next = {spk_ctrl_reg[7:1], spk_short_reg};
            end
            default: begin
               rdata_next = 8'h00;
            end
         endcase
      end else if (sel_p0 && req.addr == ODPC_OFS_STICKY) begin
         rdata_next[ODPC_STICKY_SPK] = sticky_reg;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata  <= 8'h00;
         rvalid <= 1'b0;
      end else begin
         rvalid <= req.rd;
         if (req.rd) begin
            rdata <= rdata_next;
         end
      end
   end

   // Driver controls
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         drv              <= '0;
         spk_short_sticky <= 1'b0;
      end else begin
         drv.left_headphone_driver_en  <= hp_ctrl_reg[ODPC_HP_LEFT_EN] && !hp_trip;
         drv.right_headphone_driver_en <= hp_ctrl_reg[ODPC_HP_RIGHT_EN] && !hp_trip;
         drv.hp_cm_level               <= hp_ctrl_reg[ODPC_HP_CM_HI:ODPC_HP_CM_LO];
         drv.hp_current_limit          <= hp_short_reg && !hp_ctrl_reg[ODPC_HP_SHORT_PD];
         drv.spk_driver_en             <= spk_ctrl_reg[ODPC_SPK_EN];
         spk_short_sticky              <= sticky_reg;
      end
   end
endmodule : odpc_regs

// ---- verification/odpc_checker.sv ----
// Purpose: Port assertions for the output driver power control bank
// Assumes: Sees only the bank ports and tracks the page itself
// Notes:   Bound to odpc_regs after the module
`timescale 1ns/100ps
module odpc_checker import odpc_pkg::*; (
   input wire logic      ref_clk, rst_n, hp_short_raw, spk_short_raw, rvalid, spk_short_sticky,
   input wire logic [7:0] rdata,
   input wire odpc_req_t req,
   input wire odpc_drv_t drv
);
   logic [7:0] pg;
   logic       w1;
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n) pg <= 8'h00;
      else if (req.wr && req.addr == 8'h00) pg <= req.wdata;
   assign w1 = req.wr && pg == 8'h01;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_read_answer: assert property (req.rd |=> rvalid)
      else $error("read without answer");
   a_rdata_hold: assert property (!rvalid |-> $stable(rdata))
      else $error("read data moved");
   a_reserved_zero: assert property (req.rd && req.addr inside {[8'h01:8'h1D]} |=> rdata == 8'h00)
      else $error("reserved read not zero");
   a_hp_power: assert property ((!hp_short_raw)[*6] ##0 (w1 && req.addr == 8'h1F) |-> ##2
      {drv.left_headphone_driver_en, drv.right_headphone_driver_en} == $past(req.wdata[7:6], 2))
      else $error("headphone enables wrong");
   a_cm_level: assert property (w1 && req.addr == 8'h1F |-> ##2 drv.hp_cm_level == $past(req.wdata[4:3], 2))
      else $error("common mode level wrong");
   a_spk_power: assert property ((!spk_short_raw)[*6] ##0 (w1 && req.addr == 8'h20) |-> ##2
      drv.spk_driver_en == $past(req.wdata[7], 2))
      else $error("speaker enable wrong");
   a_no_limit: assert property ((!hp_short_raw)[*8] |-> !drv.hp_current_limit)
      else $error("limit without short");
   a_no_sticky: assert property ((!spk_short_raw)[*8] |-> !$rose(spk_short_sticky))
      else $error("sticky without short");
   c_hp_trip: cover property (hp_short_raw ##8 !drv.left_headphone_driver_en);
   c_sticky: cover property ($rose(spk_short_sticky));
   c_page_top: cover property (req.wr && req.addr == 8'h00 && req.wdata == 8'hFF);
endmodule : odpc_checker
bind odpc_regs odpc_checker chk_i (.ref_clk, .rst_n, .hp_short_raw, .spk_short_raw, .rvalid,
   .spk_short_sticky, .rdata, .req, .drv);

// ---- verification/odpc_host.sv ----
// Purpose: Host model issuing register requests to the bank
// Assumes: Requests move just after a rising edge, one pulse each
// Notes:   Keeps the host side write restrictions
`timescale 1ns/100ps
module odpc_host (
   input  wire logic          ref_clk,
   output odpc_pkg::odpc_req_t req
);
   import odpc_pkg::*;
   initial req = '0;
   task automatic acc(input logic w, input logic [7:0] a, d);
      logic [7:0] dd;
      dd = d;
      if (a == 8'h1F) dd[5:2] = {1'b0, d[4:3], 1'b1};
      if (a == 8'h20) dd[5:0] = 6'h06;
      if (w && a inside {[8'h01:8'h1D]}) return;
      @(posedge ref_clk);
      req <= {w, !w, a, dd};
      @(posedge ref_clk);
      req <= '0;
   endtask : acc
endmodule : odpc_host

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the output driver power bank
// Assumes: Host model issues every request
// Notes:   Row table first, then reset and short cases
`timescale 1ns/100ps
module tb_top;
   import odpc_pkg::*;
   logic ref_clk, rst_n, hp_s, spk_s, rvalid, sticky;
   logic [7:0] rdata;
   odpc_req_t req;
   odpc_drv_t drv;
   int mismatches = 0, checked = 0, cyc = 0;
   logic [31:0] rows [13] = '{32'h011E0303, 32'h011E0000, 32'h011FC4C4, 32'h011FCCCC,
      32'h011FD4D4, 32'h011FDCDC, 32'h011F0504, 32'h01208686, 32'h01200606, 32'h001FC400,
      32'h01057700, 32'h0000FFFF, 32'h01000000};
   odpc_host host (.ref_clk, .req);
   odpc_regs uut (.ref_clk, .rst_n, .req, .hp_short_raw(hp_s), .spk_short_raw(spk_s),
      .rdata, .rvalid, .spk_short_sticky(sticky), .drv);
   initial begin
      ref_clk = 0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic chk(input string n, input logic [7:0] e, v);
      checked++;
      if (v !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, v);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, e, m);
      host.acc(1'b0, a, 8'h00);
      #1 chk("rdata", e, rdata & m);
      chk("rvalid", 8'h01, {7'h00, rvalid});
   endtask : rd
   task automatic sc(input logic [7:0] ec, a, d, input logic hp, input logic [7:0] e, m, ed);
      host.acc(1'b1, 8'h1E, ec);
      host.acc(1'b1, a, d);
      hp_s <= hp;
      spk_s <= !hp;
      repeat (8) @(posedge ref_clk);
      rd(a, e, m);
      chk("drv", ed, {2'b00, drv});
      @(posedge ref_clk);
      hp_s <= 1'b0;
      spk_s <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask : sc
   task automatic conclude;
      $display("Comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   initial begin
      rst_n = 0;
      hp_s = 0;
      spk_s = 0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         host.acc(1'b1, 8'h00, rows[i][31:24]);
         host.acc(1'b1, rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0], 8'hFF);
      end
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(8'h00, 8'h00, 8'hFF);
      chk("drv", 8'h00, {2'b00, drv});
      host.acc(1'b1, 8'h00, 8'h01);
      rd(8'h1E, 8'h00, 8'hFF);
      rd(8'h1F, 8'h04, 8'hFF);
      rd(8'h20, 8'h06, 8'hFF);
      sc(8'h00, 8'h1F, 8'hC6, 1'b1, 8'h07, 8'hFF, 8'h00);
      sc(8'h01, 8'h1F, 8'hC6, 1'b1, 8'hC7, 8'hFF, 8'h00);
      sc(8'h00, 8'h1F, 8'hC4, 1'b1, 8'hC5, 8'hFF, 8'h32);
      sc(8'h00, 8'h20, 8'h86, 1'b0, 8'h06, 8'hFE, 8'h30);
      sc(8'h02, 8'h20, 8'h86, 1'b0, 8'h87, 8'hFF, 8'h31);
      chk("sticky", 8'h01, {7'h00, sticky});
      host.acc(1'b1, 8'h00, 8'h00);
      rd(8'h2C, 8'h01, 8'hFF);
      rd(8'h2C, 8'h00, 8'hFF);
      chk("sticky", 8'h00, {7'h00, sticky});
      conclude();
   end
endmodule : tb_top
